/* rtl/ltx_regs.vh */
// Register map, field positions, reset values and codes of the line control.
`ifndef LTX_REGS_VH
`define LTX_REGS_VH
`define LTX_CTL2_ADDR 16'h3c08
`define LTX_CTL2_INDEX 16'h0f02
`define LTX_PAT_ADDR 16'h3c04
`define LTX_DET_ADDR 16'h3c0c
`define LTX_STAT_ADDR 16'h3c10
`define LTX_TX_DRIVER_ENABLE_PIN_BIT 3
`define LTX_LOOP_HI 2
`define LTX_LOOP_LO 0
`define LTX_CTL2_RST 8'h00
`define LTX_PAT_RST 3'h0
`define LTX_DET_RST 2'h0
`define LTX_PAT_LUC 3'h6
`define LTX_PAT_LDC 3'h7
`define LTX_LB_NONE 3'h0
`define LTX_LB_DUAL 3'h4
`define LTX_LB_ANA 3'h5
`define LTX_LB_REM 3'h6
`define LTX_LB_DIG 3'h7
`define LTX_LUC_PAT 5'h01
`define LTX_LDC_PAT 5'h03
`endif

/* rtl/ltx_line_ctl.v */
// Transmit driver gating and loop-back control for one line channel.
`timescale 1ns/10ps
`include "ltx_regs.vh"

// Notes on behaviour
// [RQ1] Control bit 3 turns the driver on; zero tri-states tip and ring.
// [RQ2] Driver is on only while enable pin is high and bit is set.
// [RQ3] Bits 2..0 select loop-back: none, dual, analog, remote, digital.
// [RQ4] While sending loop-up code, ignore loop-code detect and remote loop.
// [RQ5] Pattern code 111 sends a repeating loop-down code on the line.
module ltx_line_ctl (
	input wire clk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire tx_driver_enable_pin,
	input wire tx_data_in,
	input wire [1:0] rx_code_seen,
	output reg line_out_tip,
	output reg line_out_ring,
	output reg line_out_tip_oe_n,
	output reg line_out_ring_oe_n,
	output reg [2:0] loopback_mode_sel,
	output reg loop_remote_auto,
	output reg [1:0] code_detect_out
);

	reg pin_s1_r;
	reg pin_s2_r;
	reg [7:0] ctl2_r;
	reg [2:0] pat_r;
	reg [2:0] pat_prev_r;
	reg [1:0] loop_code_detect_enable_r;
	reg [4:0] code_sh_r;
	reg data_r;
	reg drv_on;
	reg send_loop_up_code;
	reg send_loop_down_code;
	reg [1:0] det_eff;
	reg [2:0] lb_eff;
	reg line_bit;
	wire acc;
	wire wr;

	// Compares a bus address with one register's byte address.
	function is_addr;
		input [15:0] a;
		input [15:0] ref_a;
		begin
			is_addr = (a == ref_a);
		end
	endfunction

	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;

	// The pin is asynchronous to clk, so it is synchronised first.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			data_r <= 1'b0;
		end else begin
			pin_s1_r <= tx_driver_enable_pin;
			pin_s2_r <= pin_s1_r;
			data_r <= tx_data_in;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctl2_r <= `LTX_CTL2_RST; // see [RQ1] see [RQ3]
			pat_r <= `LTX_PAT_RST;
			loop_code_detect_enable_r <= `LTX_DET_RST;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				prdata <= 32'h00000000;
				if (is_addr(paddr, `LTX_CTL2_ADDR))
					prdata <= {24'h000000, ctl2_r};
				else if (is_addr(paddr, `LTX_PAT_ADDR))
					prdata <= {29'h00000000, pat_r};
				else if (is_addr(paddr, `LTX_DET_ADDR))
					prdata <= {30'h00000000, loop_code_detect_enable_r};
				else if (is_addr(paddr, `LTX_STAT_ADDR))
					prdata <= {26'h0000000, send_loop_up_code, drv_on,
						pin_s2_r, lb_eff};
				else
					pslverr <= 1'b1;
			end
			if (wr) begin
				if (is_addr(paddr, `LTX_CTL2_ADDR))
					ctl2_r <= pwdata[7:0];
				if (is_addr(paddr, `LTX_PAT_ADDR))
					pat_r <= pwdata[2:0];
				if (is_addr(paddr, `LTX_DET_ADDR))
					loop_code_detect_enable_r <= pwdata[1:0];
			end
		end
	end

	always @* begin
		drv_on = pin_s2_r & ctl2_r[`LTX_TX_DRIVER_ENABLE_PIN_BIT]; // see [RQ1] see [RQ2]
		send_loop_up_code = (pat_r == `LTX_PAT_LUC);
		send_loop_down_code = (pat_r == `LTX_PAT_LDC);
		// Suppressing detection avoids looping ourselves when far end answers.
		det_eff = send_loop_up_code ? 2'h0 :
			loop_code_detect_enable_r; // see [RQ4]
		lb_eff = ctl2_r[`LTX_LOOP_HI:`LTX_LOOP_LO]; // see [RQ3]
		if (send_loop_up_code)
			line_bit = code_sh_r[4];
		else if (send_loop_down_code)
			line_bit = code_sh_r[4]; // see [RQ5]
		else
			line_bit = data_r;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			code_sh_r <= 5'h00;
			pat_prev_r <= `LTX_PAT_RST;
			line_out_tip <= 1'b0;
			line_out_ring <= 1'b0;
			line_out_tip_oe_n <= 1'b1;
			line_out_ring_oe_n <= 1'b1;
			loopback_mode_sel <= `LTX_LB_NONE;
			loop_remote_auto <= 1'b0;
			code_detect_out <= 2'h0;
		end else begin
			// A new loop-code selector value reloads the shifter, so that a
			// switch between codes never keeps rotating the old one.
			pat_prev_r <= pat_r;
			if (send_loop_up_code &
				((code_sh_r == 5'h00) | (pat_r != pat_prev_r)))
				code_sh_r <= `LTX_LUC_PAT;
			else if (send_loop_down_code &
				((code_sh_r == 5'h00) | (pat_r != pat_prev_r)))
				code_sh_r <= `LTX_LDC_PAT; // see [RQ5]
			else if (send_loop_up_code | send_loop_down_code)
				code_sh_r <= {code_sh_r[3:0], code_sh_r[4]};
			else
				code_sh_r <= 5'h00;
			line_out_tip <= drv_on & line_bit;
			line_out_ring <= drv_on & ~line_bit;
			line_out_tip_oe_n <= ~drv_on; // see [RQ1] see [RQ2]
			line_out_ring_oe_n <= ~drv_on;
			loopback_mode_sel <= lb_eff;
			code_detect_out <= det_eff;
			loop_remote_auto <= ~send_loop_up_code &
				(rx_code_seen[0] & det_eff[0]); // see [RQ4]
		end
	end

endmodule // ltx_line_ctl

/* bench/ltx_line_ctl_props.sv */
// Port checker for driver gating and loop-back select.
`timescale 1ns/10ps
`include "ltx_regs.vh"
module ltx_line_ctl_props (
	input wire clk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire pready,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire tx_driver_enable_pin,
	input wire line_out_tip,
	input wire line_out_ring,
	input wire line_out_tip_oe_n,
	input wire [2:0] loopback_mode_sel
);
	wire wr = psel && penable && pready && pwrite && paddr == `LTX_CTL2_ADDR;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_pin;
		tx_driver_enable_pin [*3];
	endsequence
	chk_ring_inv: assert property (
		!line_out_tip_oe_n |-> line_out_ring != line_out_tip) else $error("ring");
	chk_bit_off: assert property (
		wr && !pwdata[3] |-> ##[1:3] line_out_tip_oe_n) else $error("bit off");
	chk_pin_off: assert property (
		!tx_driver_enable_pin [*3] |=> line_out_tip_oe_n) else $error("pin off");
	chk_pin_on: assert property (
		s_pin ##0 (wr && pwdata[3]) |-> ##[1:3] !line_out_tip_oe_n)
		else $error("pin on");
	chk_lb_sel: assert property (
		wr |-> ##2 ({29'h0, loopback_mode_sel} == ($past(pwdata, 2) & 32'h7)))
		else $error("loop sel");
endmodule // ltx_line_ctl_props
bind ltx_line_ctl ltx_line_ctl_props u_chk (.*);

/* bench/ltx_far_end.sv */
// Far-end terminal model that recognises loop codes on the line.
`timescale 1ns/10ps
`include "ltx_regs.vh"
module ltx_far_end (
	input wire clk,
	input wire nrst,
	input wire line_out_tip,
	input wire line_out_tip_oe_n,
	output reg [1:0] rx_code_seen
);
	reg [4:0] sh_r;
	// A released line carries nothing, so only driven bits are heard.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sh_r <= 5'h1f;
			rx_code_seen <= 2'h0;
		end else if (!line_out_tip_oe_n) begin
			sh_r <= {sh_r[3:0], line_out_tip};
			if (sh_r == `LTX_LUC_PAT)
				rx_code_seen <= 2'h1;
			if (sh_r == `LTX_LDC_PAT)
				rx_code_seen <= 2'h2;
		end
	end
endmodule // ltx_far_end

/* bench/ltx_line_ctl_tb.sv */
// Bench for the line control over its register bus.
`timescale 1ns/10ps
`include "ltx_regs.vh"
module ltx_line_ctl_tb;
	reg clk, nrst, psel, penable, pwrite, tx_driver_enable_pin, tx_data_in, er;
	reg [15:0] paddr;
	reg [31:0] pwdata, rd, c;
	wire [31:0] prdata;
	wire pready, pslverr, line_out_tip, line_out_ring, line_out_tip_oe_n;
	wire line_out_ring_oe_n, loop_remote_auto;
	wire [1:0] rx_code_seen, code_detect_out;
	wire [2:0] loopback_mode_sel;
	integer n_mismatch, comparisons, i;
	ltx_line_ctl u_dut (.*);
	ltx_far_end u_far (.*);
	task end_sim;
		begin
			$display("mismatches %0d of %0d", n_mismatch, comparisons);
			if (n_mismatch == 0 && comparisons > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task ck(input [39:0] nm, input [31:0] e, input [31:0] s);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %s exp %h got %h", nm, e, s);
			end
		end
	endtask
	task ap(input [15:0] a, input w, input [31:0] d);
		integer n;
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			n = 0;
			@(negedge clk);
			while (pready !== 1'b1 && n < 9) begin
				@(negedge clk);
				n = n + 1;
			end
			rd = prdata;
			er = pslverr;
			@(posedge clk);
			psel <= 1'b0;
			penable <= 1'b0;
			if (n == 9) begin
				n_mismatch = n_mismatch + 1;
				end_sim;
			end
			@(posedge clk);
		end
	endtask
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		{nrst, psel, penable, pwrite, tx_driver_enable_pin, paddr, pwdata} = 0;
		tx_data_in = 1;
		n_mismatch = 0;
		comparisons = 0;
		repeat (20) @(posedge clk);
		nrst <= 1;
		ap(`LTX_CTL2_ADDR, 0, 0);
		ck("ctl", 32'h0, rd);
		ck("oe", 32'h1, line_out_tip_oe_n);
		tx_driver_enable_pin <= 1;
		ap(`LTX_CTL2_ADDR, 1, 32'h8);
		repeat (4) @(posedge clk);
		ck("oe", 32'h0, line_out_tip_oe_n);
		tx_driver_enable_pin <= 0;
		repeat (4) @(posedge clk);
		ck("oe", 32'h1, line_out_tip_oe_n);
		tx_driver_enable_pin <= 1;
		ap(`LTX_CTL2_ADDR, 1, 32'h0);
		repeat (4) @(posedge clk);
		ck("oe", 32'h1, line_out_tip_oe_n);
		$display("driver test done");
		for (i = 0; i < 5; i = i + 1) begin
			c = 32'h8 | (i == 4 ? 0 : i + 4);
			ap(`LTX_CTL2_ADDR, 1, c);
			ap(`LTX_CTL2_ADDR, 0, 0);
			ck("ctl", c, rd);
			ck("lb", c & 32'h7, loopback_mode_sel);
		end
		ap(16'h0ff0, 0, 0);
		ck("err", 32'h1, er);
		$display("loop test done");
		ap(`LTX_DET_ADDR, 1, 32'h3);
		ap(`LTX_PAT_ADDR, 1, 32'h6);
		repeat (40) @(posedge clk);
		ck("det", 32'h0, code_detect_out);
		ck("auto", 32'h0, loop_remote_auto);
		ck("seen", 32'h1, rx_code_seen);
		ap(`LTX_PAT_ADDR, 1, 32'h7);
		repeat (40) @(posedge clk);
		ck("seen", 32'h2, rx_code_seen);
		ck("det", 32'h3, code_detect_out);
		$display("code test done");
		end_sim;
	end
endmodule // ltx_line_ctl_tb
